// *** maf_params.svh ***
`ifndef MAF_PARAMS_SVH
`define MAF_PARAMS_SVH

// ****************************************************************
// Register byte offsets
// ****************************************************************
`define MAF_OFS_NET_CTRL 8'h00
`define MAF_OFS_NET_CFG 8'h04
`define MAF_OFS_SM2_LOW 8'h08
`define MAF_OFS_SM2_HIGH 8'h0c
`define MAF_OFS_SM3_LOW 8'h10
`define MAF_OFS_SM3_HIGH 8'h14
`define MAF_OFS_SM4_LOW 8'h18
`define MAF_OFS_SM4_HIGH 8'h1c
`define MAF_OFS_TYPE_CMP 8'h20
`define MAF_OFS_PHY_CTRL 8'h24
`define MAF_OFS_PAUSE_CNT 8'h28
`define MAF_OFS_TXOK_CNT 8'h2c
`define MAF_OFS_ONECOL_CNT 8'h30

// ****************************************************************
// Field positions
// ****************************************************************
`define MAF_BIT_RX_ENABLE 2
`define MAF_BIT_STAT_WE 7
`define MAF_BIT_LONG_FRAME 8
`define MAF_BIT_RMII 0
`define MAF_BIT_XCVR_CLK 1

// ****************************************************************
// Reset values, frame limits and counter widths
// ****************************************************************
`define MAF_RST_WORD 32'h0000_0000
`define MAF_RST_PHY_CTRL 2'h0
`define MAF_LEN_MIN 11'h040
`define MAF_LEN_MAX 11'h5ee
`define MAF_LEN_MAX_LONG 11'h600
`define MAF_PAUSE_W 16
`define MAF_TXOK_W 24
`define MAF_ONECOL_W 16

`endif

// *** maf_phy_model.sv ***
`timescale 1ns/1ps
// ****************************************
// Link partner that reports frame events.
// ****************************************
module maf_phy_model (
  // Clock.
  input wire logic core_clk,
  // Events towards the block.
  output maf_pkg::maf_rx_evt_s rx_evt,
  output maf_pkg::maf_tx_evt_s tx_evt,
  // Block outputs seen.
  input wire logic [2:0] station_hit,
  input wire logic type_hit
);
  import maf_pkg::*;
  logic [2:0] hit_seen;
  logic type_seen;
  initial begin
    rx_evt = '0;
    tx_evt = '0;
    hit_seen = '0;
    type_seen = 1'b0;
  end
  // Idle fields are scrambled so that no stale value looks valid.
  task automatic rx(input logic [10:0] len, input logic [2:0] er,
                    input logic pz, input logic [47:0] d,
                    input logic [15:0] t);
    @(posedge core_clk);
    rx_evt <= {1'b1, len, er, pz, d, t};
    @(negedge core_clk);
    hit_seen = station_hit;
    type_seen = type_hit;
    @(posedge core_clk);
    rx_evt <= {1'b0, ~rx_evt[78:0]};
  endtask
  task automatic tx(input logic u, input logic r, input logic [4:0] c);
    @(posedge core_clk);
    tx_evt <= {1'b1, u, r, c};
    @(posedge core_clk);
    tx_evt <= {1'b0, ~tx_evt[6:0]};
  endtask
endmodule

// *** maf_pkg.sv ***
package maf_pkg;

  typedef enum {
    MAF_R_NONE, MAF_R_CTRL, MAF_R_CFG, MAF_R_SM_LOW, MAF_R_SM_HIGH,
    MAF_R_TYPE, MAF_R_PHY, MAF_R_PAUSE, MAF_R_TXOK, MAF_R_ONECOL
  } maf_reg_e;

  typedef struct packed {
    logic valid;
    logic [10:0] length;
    logic fcs_err;
    logic align_err;
    logic symbol_err;
    logic is_pause;
    logic [47:0] dest;
    logic [15:0] type_len;
  } maf_rx_evt_s;

  typedef struct packed {
    logic valid;
    logic underrun;
    logic retry_limit;
    logic [4:0] collisions;
  } maf_tx_evt_s;

endpackage

// *** maf_regs.sv ***
// Added by the designer: register access over APB and the register addresses.
`timescale 1ns/1ps
`include "maf_params.svh"
// Functional notes
// [RQ1] Low station registers hold address bits 31:0; bit 0 is the group bit.
// [RQ2] High station registers hold bits 47:32 in 15:0; upper bits read zero.
// [RQ3] The 16-bit type value is compared with each received type field.
// [RQ4] Interface-select bit one gives RMII mode, zero gives MII mode.
// [RQ5] Transceiver clock bit one passes the clock; zero blocks it.
// [RQ6] Reading a statistics counter clears it to zero.
// [RQ7] Statistics counters stick at all ones instead of wrapping.
// [RQ8] Receive counters advance only while receive enable is set.
// [RQ9] Counter writes work only while control bit 7 is set.
// [RQ10] Software reads counters often enough to avoid saturation.
// [RQ11] Pause counter is 16 bits and counts good pause frames.
// [RQ12] Good frame: 64 to 1518 bytes, 1536 if long, no errors.
// [RQ13] Transmit-OK counter is 24 bits, no underrun, retry limit kept.
// [RQ14] One-collision counter is 16 bits, success after exactly one collision.
module maf_regs (
  // Clock and reset.
  input wire logic core_clk,
  input wire logic rstn,
  // APB slave.
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [7:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  // Frame events.
  input wire maf_pkg::maf_rx_evt_s rx_evt,
  input wire maf_pkg::maf_tx_evt_s tx_evt,
  // Filter results and PHY controls.
  output logic [2:0] station_hit,
  output logic type_hit,
  output logic rmii_mode,
  output logic xcvr_clock_on
);
  import maf_pkg::*;

  // ****************************************************************
  // Address decode
  // ****************************************************************
  function automatic maf_reg_e dec(input logic [7:0] a);
    if (a == `MAF_OFS_NET_CTRL) begin
      return MAF_R_CTRL;
    end else if (a == `MAF_OFS_NET_CFG) begin
      return MAF_R_CFG;
    end else if (a == `MAF_OFS_SM2_LOW || a == `MAF_OFS_SM3_LOW ||
                 a == `MAF_OFS_SM4_LOW) begin
      return MAF_R_SM_LOW;
    end else if (a == `MAF_OFS_SM2_HIGH || a == `MAF_OFS_SM3_HIGH ||
                 a == `MAF_OFS_SM4_HIGH) begin
      return MAF_R_SM_HIGH;
    end else if (a == `MAF_OFS_TYPE_CMP) begin
      return MAF_R_TYPE;
    end else if (a == `MAF_OFS_PHY_CTRL) begin
      return MAF_R_PHY;
    end else if (a == `MAF_OFS_PAUSE_CNT) begin
      return MAF_R_PAUSE;
    end else if (a == `MAF_OFS_TXOK_CNT) begin
      return MAF_R_TXOK;
    end else if (a == `MAF_OFS_ONECOL_CNT) begin
      return MAF_R_ONECOL;
    end else begin
      return MAF_R_NONE;
    end
  endfunction

  // Saturating counter step; a clear still keeps a same-cycle event.
  function automatic logic [23:0] cnt_step(input logic [23:0] cur,
      input logic [23:0] maxv, input logic inc, input logic clr);
    if (clr) begin
      return {23'h0, inc};
    end else if (inc && cur != maxv) begin
      return cur + 24'h1;
    end else begin
      return cur;
    end
  endfunction

  maf_reg_e sel;
  logic rd_take;
  logic wr_take;
  logic [1:0] slot;
  assign sel = dec(paddr);
  assign rd_take = psel && !penable && !pwrite;
  assign wr_take = psel && penable && pwrite;
  assign slot = (paddr[4:3] == 2'h1) ? 2'h0 :
                (paddr[4:3] == 2'h2) ? 2'h1 : 2'h2;
  assign pready = 1'b1;

  // ****************************************************************
  // Control and filter registers
  // ****************************************************************
  logic rx_en_q;
  logic stat_we_q;
  logic long_q;
  logic [15:0] tid_q;
  logic [1:0] phy_q;
  logic [31:0] sm_low_q [3];
  logic [15:0] sm_high_q [3];

  always_ff @(posedge core_clk or negedge rstn) begin
    if (!rstn) begin
      rx_en_q <= 1'b0;
      stat_we_q <= 1'b0;
      long_q <= 1'b0;
      tid_q <= 16'h0;
      phy_q <= `MAF_RST_PHY_CTRL;
    end else if (wr_take) begin
      if (sel == MAF_R_CTRL) begin
        rx_en_q <= pwdata[`MAF_BIT_RX_ENABLE];
        stat_we_q <= pwdata[`MAF_BIT_STAT_WE];
      end
      if (sel == MAF_R_CFG) begin
        long_q <= pwdata[`MAF_BIT_LONG_FRAME];
      end
      if (sel == MAF_R_TYPE) begin
        tid_q <= pwdata[15:0];
      end
      if (sel == MAF_R_PHY) begin
        phy_q <= {pwdata[`MAF_BIT_XCVR_CLK], pwdata[`MAF_BIT_RMII]};
      end
    end
  end

  genvar g;
  generate
    for (g = 0; g < 3; g++) begin : gen_slot
      always_ff @(posedge core_clk or negedge rstn) begin
        if (!rstn) begin
          sm_low_q[g] <= `MAF_RST_WORD;
          sm_high_q[g] <= 16'h0;
        end else if (wr_take && slot == 2'(g)) begin
          if (sel == MAF_R_SM_LOW) begin
            sm_low_q[g] <= pwdata; // RQ1
          end
          if (sel == MAF_R_SM_HIGH) begin
            sm_high_q[g] <= pwdata[15:0]; // RQ2
          end
        end
      end
      assign station_hit[g] = rx_evt.valid &&
          rx_evt.dest == {sm_high_q[g], sm_low_q[g]}; // RQ1
    end
  endgenerate

  assign type_hit = rx_evt.valid && rx_evt.type_len == tid_q; // RQ3
  assign rmii_mode = phy_q[0]; // RQ4
  assign xcvr_clock_on = phy_q[1]; // RQ5

  // ****************************************************************
  // Statistics counters
  // ****************************************************************
  logic [10:0] len_top;
  logic rx_good;
  logic pause_inc;
  logic txok_inc;
  logic onecol_inc;
  logic [15:0] pause_q;
  logic [23:0] txok_q;
  logic [15:0] onecol_q;
  logic [23:0] pause_d;
  logic [23:0] txok_d;
  logic [23:0] onecol_d;
  logic st_wr;

  assign len_top = long_q ? `MAF_LEN_MAX_LONG : `MAF_LEN_MAX;
  assign rx_good = rx_evt.length >= `MAF_LEN_MIN &&
      rx_evt.length <= len_top && !rx_evt.fcs_err &&
      !rx_evt.align_err && !rx_evt.symbol_err; // RQ12
  assign pause_inc = rx_evt.valid && rx_evt.is_pause && rx_good &&
      rx_en_q; // RQ8 RQ11
  assign txok_inc = tx_evt.valid && !tx_evt.underrun &&
      !tx_evt.retry_limit; // RQ13
  assign onecol_inc = txok_inc && tx_evt.collisions == 5'h1; // RQ14
  assign st_wr = wr_take && stat_we_q; // RQ9

  assign pause_d = cnt_step({8'h0, pause_q}, 24'h00ffff, pause_inc,
      rd_take && sel == MAF_R_PAUSE); // RQ6 RQ7
  assign txok_d = cnt_step(txok_q, 24'hffffff, txok_inc,
      rd_take && sel == MAF_R_TXOK); // RQ6 RQ7
  assign onecol_d = cnt_step({8'h0, onecol_q}, 24'h00ffff, onecol_inc,
      rd_take && sel == MAF_R_ONECOL); // RQ6 RQ7

  always_ff @(posedge core_clk or negedge rstn) begin
    if (!rstn) begin
      pause_q <= 16'h0;
      txok_q <= 24'h0;
      onecol_q <= 16'h0;
    end else begin
      pause_q <= (st_wr && sel == MAF_R_PAUSE) ? pwdata[15:0] :
          pause_d[15:0]; // RQ9
      txok_q <= (st_wr && sel == MAF_R_TXOK) ? pwdata[23:0] : txok_d;
      onecol_q <= (st_wr && sel == MAF_R_ONECOL) ? pwdata[15:0] :
          onecol_d[15:0];
    end
  end

  // ****************************************************************
  // Read data, captured in the setup phase
  // ****************************************************************
  logic [31:0] rd_mux;
  assign rd_mux =
      (sel == MAF_R_CTRL) ? 32'({stat_we_q, 4'h0, rx_en_q, 2'h0}) :
      (sel == MAF_R_CFG) ? 32'({long_q, 8'h0}) :
      (sel == MAF_R_SM_LOW) ? sm_low_q[slot] :
      (sel == MAF_R_SM_HIGH) ? {16'h0, sm_high_q[slot]} : // RQ2
      (sel == MAF_R_TYPE) ? {16'h0, tid_q} :
      (sel == MAF_R_PHY) ? {30'h0, phy_q} :
      (sel == MAF_R_PAUSE) ? {16'h0, pause_q} :
      (sel == MAF_R_TXOK) ? {8'h0, txok_q} :
      (sel == MAF_R_ONECOL) ? {16'h0, onecol_q} : 32'h0;

  always_ff @(posedge core_clk or negedge rstn) begin
    if (!rstn) begin
      prdata <= 32'h0;
      pslverr <= 1'b0;
    end else if (psel && !penable) begin
      prdata <= pwrite ? 32'h0 : rd_mux;
      pslverr <= (sel == MAF_R_NONE);
    end
  end

  // ****************************************************************
  // Checks
  // ****************************************************************
  default clocking cb @(posedge core_clk); endclocking
  default disable iff (!rstn);

  chk_low_match: assert property ( // RQ1
    station_hit[0] |-> rx_evt.dest[31:0] == sm_low_q[0])
    else $error("station hit without low word match");
  chk_high_zero: assert property ( // RQ2
    rd_take && sel == MAF_R_SM_HIGH |=> prdata[31:16] == 16'h0)
    else $error("station high upper bits not zero");
  chk_type_hit: assert property ( // RQ3
    rx_evt.valid && rx_evt.type_len == tid_q |-> type_hit)
    else $error("type compare missed");
  chk_rmii_sel: assert property ( // RQ4
    wr_take && sel == MAF_R_PHY |=> rmii_mode == $past(pwdata[0]))
    else $error("interface select not applied");
  chk_xcvr_gate: assert property ( // RQ5
    wr_take && sel == MAF_R_PHY |=> xcvr_clock_on == $past(pwdata[1]))
    else $error("transceiver clock gate not applied");
  chk_read_clear: assert property ( // RQ6
    rd_take && sel == MAF_R_TXOK && !txok_inc |=> txok_q == 24'h0)
    else $error("counter not cleared by read");
  chk_saturate: assert property ( // RQ7
    pause_q == 16'hffff && !rd_take && !wr_take |=> pause_q == 16'hffff)
    else $error("pause counter wrapped");
  chk_rx_gate: assert property ( // RQ8
    !rx_en_q && !rd_take && !wr_take |=> $stable(pause_q))
    else $error("receive counter moved while disabled");
  chk_stat_wr: assert property ( // RQ9
    wr_take && sel == MAF_R_ONECOL && !stat_we_q && !onecol_inc
    |=> $stable(onecol_q))
    else $error("counter written without write enable");
  chk_pause_inc: assert property ( // RQ11
    pause_inc && pause_q != 16'hffff && !rd_take && !wr_take
    |=> pause_q == $past(pause_q) + 16'h1)
    else $error("pause counter did not advance");
  chk_good_len: assert property ( // RQ12
    pause_inc |-> rx_evt.length >= `MAF_LEN_MIN &&
    rx_evt.length <= `MAF_LEN_MAX_LONG)
    else $error("pause counted for bad length");
  chk_txok_inc: assert property ( // RQ13
    tx_evt.valid && tx_evt.underrun && !rd_take && !wr_take
    |=> $stable(txok_q))
    else $error("underrun frame counted as ok");
  chk_onecol: assert property ( // RQ14
    $changed(onecol_q) && !$past(wr_take) && onecol_q != 16'h0
    |-> $past(tx_evt.collisions) == 5'h1)
    else $error("one-collision count without single collision");
  chk_txok_sat: assert property ( // RQ7
    txok_q == 24'hffffff && !rd_take && !wr_take |=> txok_q == 24'hffffff)
    else $error("transmit counter wrapped");
  chk_onecol_sat: assert property ( // RQ7
    onecol_q == 16'hffff && !rd_take && !wr_take |=> onecol_q == 16'hffff)
    else $error("one-collision counter wrapped");
  chk_clr_wins: assert property ( // RQ6
    rd_take && sel == MAF_R_PAUSE && pause_inc |=> pause_q == 16'h1)
    else $error("event lost under read clear");
  chk_hit_idle: assert property ( // RQ1
    !rx_evt.valid |-> station_hit == 3'h0 && !type_hit)
    else $error("filter hit without a frame");
  chk_xcvr_hold: assert property ( // RQ5
    !(wr_take && sel == MAF_R_PHY) |=> $stable(xcvr_clock_on))
    else $error("transceiver clock gate changed without write");
  chk_short_len: assert property ( // RQ12
    pause_inc && !long_q |-> rx_evt.length <= `MAF_LEN_MAX)
    else $error("long pause frame counted without long mode");
  chk_tx_gate: assert property ( // RQ13
    tx_evt.valid && tx_evt.retry_limit && !rd_take && !wr_take
    |=> $stable(txok_q))
    else $error("retried frame counted as ok");

  // ****************************************************************
  // Cover points
  // ****************************************************************

  cov_pause: cover property (pause_inc ##1 rd_take && sel == MAF_R_PAUSE);
  cov_sat: cover property (txok_q == 24'hffffff && txok_inc);
  cov_hit: cover property (station_hit[2] && type_hit);
  cov_clr_inc: cover property (rd_take && sel == MAF_R_TXOK && txok_inc);
  cov_phy_both: cover property (rmii_mode && xcvr_clock_on);
endmodule

// *** tb.sv ***
`timescale 1ns/1ps
`include "maf_params.svh"
module tb;
  import maf_pkg::*;
  logic core_clk, rstn, psel, penable, pwrite, pready, pslverr, err_seen;
  logic rmii_mode, xcvr_clock_on, type_hit;
  logic [7:0] paddr;
  logic [31:0] pwdata, prdata, rd;
  logic [2:0] station_hit;
  maf_rx_evt_s rx_evt;
  maf_tx_evt_s tx_evt;
  int err_total, n_compared;
  logic [10:0] lens [6] = '{11'd64, 11'd1518, 11'd63, 11'd1519, 11'd99,
                           11'd99};
  logic [2:0] errs [6] = '{3'h0, 3'h0, 3'h0, 3'h0, 3'h4, 3'h3};
  maf_regs u_maf_regs (.core_clk(core_clk), .rstn(rstn), .psel(psel),
    .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
    .prdata(prdata), .pready(pready), .pslverr(pslverr), .rx_evt(rx_evt),
    .tx_evt(tx_evt), .station_hit(station_hit), .type_hit(type_hit),
    .rmii_mode(rmii_mode), .xcvr_clock_on(xcvr_clock_on));
  maf_phy_model u_maf_phy_model (.core_clk(core_clk), .rx_evt(rx_evt),
    .tx_evt(tx_evt), .station_hit(station_hit), .type_hit(type_hit));
  initial begin
    core_clk = 1'b0;
    forever #10 core_clk = ~core_clk;
  end
  // ****************************************
  // Bus and compare tasks.
  // ****************************************
  task automatic end_of_test;
    $display("compared %0d mismatches %0d", n_compared, err_total);
    if (err_total == 0 && n_compared > 0) begin
      $display("bench passed");
    end else begin
      $display("bench failed");
    end
    $finish;
  endtask
  task automatic apb(input logic w, input logic [7:0] a,
                     input logic [31:0] d);
    int n;
    n = 0;
    @(posedge core_clk);
    psel <= 1'b1;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge core_clk);
    penable <= 1'b1;
    do begin
      @(posedge core_clk);
      n++;
    end while (pready !== 1'b1 && n < 50);
    rd = prdata;
    err_seen = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
    if (pready !== 1'b1) begin
      err_total++;
      end_of_test();
    end
  endtask
  task automatic cmp(string nm, logic [31:0] e, logic [31:0] g);
    n_compared++;
    if (g !== e) begin
      err_total++;
      $display("[ERR] %s expected %h seen %h", nm, e, g);
    end
  endtask
  task automatic rdc(string nm, logic [7:0] a, logic [31:0] e);
    apb(1'b0, a, '0);
    cmp(nm, e, rd);
  endtask
  // ****************************************
  // Main sequence.
  // ****************************************
  initial begin
    {psel, penable, pwrite, paddr, pwdata, rstn} = '0;
    err_total = 0;
    n_compared = 0;
    repeat (5) @(posedge core_clk);
    rstn <= 1'b1;
    rdc("phy_ctrl", `MAF_OFS_PHY_CTRL, 32'h0);
    for (int s = 0; s < 3; s++) begin
      apb(1'b1, 8'(`MAF_OFS_SM2_LOW + 8 * s), 32'h1234_5670 + s);
      apb(1'b1, 8'(`MAF_OFS_SM2_HIGH + 8 * s), 32'hffff_ab00 + s);
      rdc("sm_high", 8'(`MAF_OFS_SM2_HIGH + 8 * s), 32'hab00 + s);
      rdc("sm_low", 8'(`MAF_OFS_SM2_LOW + 8 * s), 32'h1234_5670 + s);
      u_maf_phy_model.rx(11'd64, 3'h0, 1'b0,
                         {16'hab00 + 16'(s), 32'h1234_5670 + s}, 16'h0);
      cmp("hit", 32'(3'h1 << s), 32'(u_maf_phy_model.hit_seen));
    end
    u_maf_phy_model.rx(11'd64, 3'h0, 1'b0, 48'hab00_1234_5671, 16'h0);
    cmp("hit_none", 32'h0, 32'(u_maf_phy_model.hit_seen));
    apb(1'b1, `MAF_OFS_TYPE_CMP, 32'h88f7);
    for (int k = 0; k < 2; k++) begin
      u_maf_phy_model.rx(11'd64, 3'h0, 1'b0, 48'h0, 16'h88f7 - 16'(k));
      cmp("type", 32'(k == 0), 32'(u_maf_phy_model.type_seen));
    end
    for (int v = 0; v < 4; v++) begin
      apb(1'b1, `MAF_OFS_PHY_CTRL, 32'(v));
      @(negedge core_clk);
      cmp("rmii", 32'(v & 1), 32'(rmii_mode));
      cmp("xclk", 32'(v >> 1), 32'(xcvr_clock_on));
    end
    u_maf_phy_model.rx(11'd64, 3'h0, 1'b1, 48'h0, 16'h8808);
    rdc("pause_off", `MAF_OFS_PAUSE_CNT, 32'h0);
    apb(1'b1, `MAF_OFS_NET_CTRL, 32'h4);
    for (int k = 0; k < 6; k++)
      u_maf_phy_model.rx(lens[k], errs[k], 1'b1, 48'h0, 16'h8808);
    u_maf_phy_model.rx(11'd64, 3'h0, 1'b0, 48'h0, 16'h0800);
    rdc("pause", `MAF_OFS_PAUSE_CNT, 32'h2);
    rdc("pause_clr", `MAF_OFS_PAUSE_CNT, 32'h0);
    apb(1'b1, `MAF_OFS_NET_CFG, 32'h100);
    u_maf_phy_model.rx(11'd1536, 3'h0, 1'b1, 48'h0, 16'h8808);
    u_maf_phy_model.rx(11'd1537, 3'h0, 1'b1, 48'h0, 16'h8808);
    rdc("pause_long", `MAF_OFS_PAUSE_CNT, 32'h1);
    u_maf_phy_model.tx(1'b0, 1'b0, 5'd1);
    u_maf_phy_model.tx(1'b1, 1'b0, 5'd1);
    u_maf_phy_model.tx(1'b0, 1'b1, 5'd1);
    u_maf_phy_model.tx(1'b0, 1'b0, 5'd2);
    u_maf_phy_model.tx(1'b0, 1'b0, 5'd0);
    rdc("txok", `MAF_OFS_TXOK_CNT, 32'h3);
    rdc("onecol", `MAF_OFS_ONECOL_CNT, 32'h1);
    apb(1'b1, `MAF_OFS_NET_CTRL, 32'h84);
    apb(1'b1, `MAF_OFS_PAUSE_CNT, 32'hffff);
    u_maf_phy_model.rx(11'd64, 3'h0, 1'b1, 48'h0, 16'h8808);
    rdc("pause_sat", `MAF_OFS_PAUSE_CNT, 32'hffff);
    apb(1'b1, `MAF_OFS_TXOK_CNT, 32'hff_ffff);
    u_maf_phy_model.tx(1'b0, 1'b0, 5'd0);
    rdc("txok_sat", `MAF_OFS_TXOK_CNT, 32'hff_ffff);
    apb(1'b1, `MAF_OFS_NET_CTRL, 32'h4);
    apb(1'b1, `MAF_OFS_ONECOL_CNT, 32'h5);
    rdc("onecol_we", `MAF_OFS_ONECOL_CNT, 32'h0);
    rdc("unmapped", 8'h40, 32'h0);
    cmp("slverr", 32'h1, 32'(err_seen));
    end_of_test();
  end
endmodule
